// ===== hdl/sam_addr_router.sv
// Address decoder and region router for processor and interconnect masters
//
// Summary of operation
// (RULE_01) Top 64 MB of the 4 GB space is the peripheral region.
// (RULE_02) Processor always reaches boot ROM and on-chip RAM in peripheral region.
// (RULE_03) 2 MB at 0xFF200000 goes to the light fabric bridge.
// (RULE_04) Processor map: 1 MB boot region at zero, SDRAM from 0x00100000.
// (RULE_05) Non-processor masters use the separate interconnect map.
// (RULE_06) Interconnect sees no boot ROM, snoop or L2 cache registers.
// (RULE_07) Interconnect 960 MB fabric region goes to the full fabric bridge.
// (RULE_08) Interconnect 2 GB at zero maps straight onto the low SDRAM.
// (RULE_09) Remap bit sends interconnect low 64 KB to on-chip RAM; reset SDRAM.
// (RULE_10) 1 GB coherent window at 0x80000000 translates to a chosen gigabyte.
// (RULE_11) Coherent-window accesses are delivered as coherent transactions.
// (RULE_12) Trace slave 48 MB at 0xFC000000; debug slave 2 MB at 0xFF000000.
// (RULE_13) Three bridge view blocks decode as 1 MB slaves.
// (RULE_14) Peripheral-bus slaves take 4 KB slots; the two MACs take 8 KB.
// (RULE_15) Two USB controllers take 256 KB at 0xFFB00000 and 0xFFB40000.
// (RULE_16) SDRAM controller registers take 128 KB at 0xFFC20000.
// (RULE_17) Snoop registers 8 KB at 0xFFFEC000; L2 registers 4 KB at 0xFFFEF000.
// (RULE_18) Boot ROM 64 KB at 0xFFFD0000; on-chip RAM 64 KB at 0xFFFF0000.
// (RULE_19) System manager takes 16 KB at 0xFFD08000.
// (RULE_20) NAND and quad flash data windows take 1 MB each.
// (RULE_21) Fabric region starts at 0xC0000000 in both maps.
// (RULE_22) Processor addresses inside filter bounds go to SDRAM, others elsewhere; in the code the peripheral region wins over the bounds.
// (RULE_23) After reset the processor boot region maps to boot ROM.
// (RULE_24) Unclaimed addresses answer with an error instead of stalling.
// (RULE_25) Config changes apply only to requests taken after the write.
`timescale 1ns/1ps
module sam_addr_router
    import sam_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              ce,
    input  wire logic [REG_AW-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              mpu_req_valid,
    input  wire logic [31:0]       mpu_req_addr,
    output logic                   mpu_rsp_valid,
    output sam_tgt_e               mpu_rsp_target,
    output logic      [31:0]       mpu_rsp_addr,
    output logic                   mpu_rsp_err,
    input  wire logic              l3_req_valid,
    input  wire logic [31:0]       l3_req_addr,
    output logic                   l3_rsp_valid,
    output sam_tgt_e               l3_rsp_target,
    output logic      [31:0]       l3_rsp_addr,
    output logic                   l3_rsp_err,
    output logic                   l3_rsp_coherent
);

    sam_cfg_if cfg ();

    sam_tgt_e          mpu_per_tgt;
    sam_tgt_e          l3_per_tgt;
    sam_tgt_e          mpu_tgt_d;
    sam_tgt_e          l3_tgt_d;
    logic [31:0]       l3_addr_d;
    logic              l3_coh_d;
    logic [FILT_W-1:0] mpu_mb;
    logic              mpu_in_filt;
    sam_tgt_e          mpu_last_q;
    sam_tgt_e          l3_last_q;
    logic [ERR_W-1:0]  err_cnt_q;

    // Saturating error counter step
    function automatic logic [ERR_W-1:0] bump(input logic [ERR_W-1:0] cnt,
                                              input logic             e);
        logic [ERR_W-1:0] nxt;
        nxt = cnt;
        if (e && (cnt != '1)) nxt = cnt + 1'b1;
        return nxt;
    endfunction

    // Register file on APB
    sam_apb_regs u_regs (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .paddr   (paddr),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .cfg     (cfg.regs)
    );

    // RULE_02 processor peripheral view
    sam_periph_dec u_mpu_dec (
        .addr    (mpu_req_addr),
        .l3_view (1'b0),
        .tgt     (mpu_per_tgt)
    );

    // RULE_06 interconnect peripheral view
    sam_periph_dec u_l3_dec (
        .addr    (l3_req_addr),
        .l3_view (1'b1),
        .tgt     (l3_per_tgt)
    );

    // RULE_22 filter bounds, megabyte granular
    assign mpu_mb      = mpu_req_addr[FILT_LSB +: FILT_W];
    assign mpu_in_filt = (mpu_mb >= cfg.filt_start) && (mpu_mb < cfg.filt_end);

    // Processor map; peripheral region wins over a filter reaching into it
    always_comb
    begin
        mpu_tgt_d = TGT_NONE;
        // RULE_01 peripheral region
        if (mpu_req_addr >= PERIPH_BASE)
            mpu_tgt_d = mpu_per_tgt;
        // RULE_22 sdram window
        else if (mpu_in_filt)
            mpu_tgt_d = TGT_SDRAM;
        // RULE_04 boot region
        else if (mpu_req_addr < MB_SIZE)
        begin
            // RULE_23 rom by default
            if (mpu_req_addr < KB64)
                mpu_tgt_d = cfg.boot_onchip ? TGT_ONCHIP_RAM : TGT_BOOT_ROM;
        end
        // RULE_21 fabric region base
        else if (mpu_req_addr >= FABRIC_BASE)
            mpu_tgt_d = TGT_FABRIC;
    end

    // RULE_05 interconnect map
    always_comb
    begin
        l3_tgt_d  = TGT_SDRAM;
        l3_addr_d = l3_req_addr;
        l3_coh_d  = 1'b0;
        // RULE_01 peripheral region
        if (l3_req_addr >= PERIPH_BASE)
            l3_tgt_d = l3_per_tgt;
        // RULE_07 full fabric bridge
        else if (l3_req_addr >= FABRIC_BASE)
            l3_tgt_d = TGT_FABRIC;
        // RULE_10 coherent window translation
        else if (l3_req_addr >= COH_BASE)
        begin
            l3_tgt_d  = TGT_COHERENT;
            l3_addr_d = {cfg.coh_page, l3_req_addr[COH_OFS_W-1:0]};
            // RULE_11 marked coherent
            l3_coh_d  = 1'b1;
        end
        // RULE_09 low memory remap
        else if ((l3_req_addr < KB64) && cfg.low_onchip)
            l3_tgt_d = TGT_ONCHIP_RAM;
        // RULE_08 direct sdram otherwise
    end

    // Processor answer, one cycle after the request is taken
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            mpu_rsp_valid  <= 1'b0;
            mpu_rsp_target <= TGT_NONE;
            mpu_rsp_addr   <= '0;
            mpu_rsp_err    <= 1'b0;
        end
        else if (ce)
        begin
            mpu_rsp_valid <= mpu_req_valid;
            if (mpu_req_valid)
            begin
                mpu_rsp_target <= mpu_tgt_d;
                mpu_rsp_addr   <= mpu_req_addr;
                // RULE_24 error not stall
                mpu_rsp_err    <= (mpu_tgt_d == TGT_NONE);
            end
        end
    end

    // Interconnect answer, same timing as the processor side
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            l3_rsp_valid    <= 1'b0;
            l3_rsp_target   <= TGT_NONE;
            l3_rsp_addr     <= '0;
            l3_rsp_err      <= 1'b0;
            l3_rsp_coherent <= 1'b0;
        end
        else if (ce)
        begin
            l3_rsp_valid <= l3_req_valid;
            if (l3_req_valid)
            begin
                l3_rsp_target   <= l3_tgt_d;
                l3_rsp_addr     <= l3_addr_d;
                // RULE_24 error not stall
                l3_rsp_err      <= (l3_tgt_d == TGT_NONE);
                l3_rsp_coherent <= l3_coh_d;
            end
        end
    end

    // Status: last targets and count of refused requests
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            mpu_last_q <= TGT_NONE;
            l3_last_q  <= TGT_NONE;
            err_cnt_q  <= '0;
        end
        else if (ce)
        begin
            if (mpu_req_valid) mpu_last_q <= mpu_tgt_d;
            if (l3_req_valid)  l3_last_q  <= l3_tgt_d;
            // Both ports may fail at once; count each
            err_cnt_q <= bump(bump(err_cnt_q, mpu_req_valid && (mpu_tgt_d == TGT_NONE)),
                              l3_req_valid && (l3_tgt_d == TGT_NONE));
        end
    end

    assign cfg.mpu_last  = mpu_last_q;
    assign cfg.l3_last   = l3_last_q;
    assign cfg.err_count = err_cnt_q;

    // Checks on routing, tied from request address to answer
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_rsp_no_stall: assert property ( // RULE_24
        ce && mpu_req_valid |=> mpu_rsp_valid ##0 (mpu_rsp_addr == $past(mpu_req_addr)))
        else $error("processor request not answered next cycle");

    a_light_window: assert property ( // RULE_03
        ce && mpu_req_valid && hit(mpu_req_addr, LW_BASE, SPAN_2MB)
        |=> mpu_rsp_target == TGT_LIGHT_FABRIC)
        else $error("light fabric window misrouted");

    a_boot_rom_default: assert property ( // RULE_23
        ce && mpu_req_valid && (mpu_req_addr < KB64) && !cfg.boot_onchip
        && (mpu_req_addr[FILT_LSB +: FILT_W] < cfg.filt_start)
        |=> mpu_rsp_target == TGT_BOOT_ROM)
        else $error("boot region not on boot ROM");

    a_filter_sdram: assert property ( // RULE_22
        ce && mpu_req_valid && mpu_in_filt && (mpu_req_addr < PERIPH_BASE)
        |=> (mpu_rsp_target == TGT_SDRAM) && !mpu_rsp_err)
        else $error("filtered address not sent to SDRAM");

    a_rom_always_seen: assert property ( // RULE_02
        ce && mpu_req_valid && hit(mpu_req_addr, ROM_BASE, KB64)
        |=> mpu_rsp_target == TGT_BOOT_ROM)
        else $error("processor lost boot ROM in peripheral region");

    a_l3_low_remap: assert property ( // RULE_09
        ce && l3_req_valid && (l3_req_addr < KB64)
        |=> l3_rsp_target == ($past(cfg.low_onchip) ? TGT_ONCHIP_RAM : TGT_SDRAM))
        else $error("interconnect low range remap wrong");

    a_l3_rom_hidden: assert property ( // RULE_06
        ce && l3_req_valid && (hit(l3_req_addr, ROM_BASE, KB64)
        || hit(l3_req_addr, SNOOP_BASE, KB8))
        |=> l3_rsp_err && (l3_rsp_target == TGT_NONE))
        else $error("processor-only slave reachable from interconnect");

    a_coherent_xlate: assert property ( // RULE_10
        ce && l3_req_valid && hit(l3_req_addr, COH_BASE, FABRIC_BASE - COH_BASE)
        |=> l3_rsp_coherent && (l3_rsp_addr[31:COH_OFS_W] == $past(cfg.coh_page))
            && (l3_rsp_addr[COH_OFS_W-1:0] == $past(l3_req_addr[COH_OFS_W-1:0])))
        else $error("coherent window translation wrong");

    a_fabric_route: assert property ( // RULE_07
        ce && l3_req_valid && hit(l3_req_addr, FABRIC_BASE, PERIPH_BASE - FABRIC_BASE)
        |=> l3_rsp_target == TGT_FABRIC)
        else $error("fabric region misrouted");

    a_frozen_hold: assert property ( // RULE_25
        !ce |=> $stable(l3_rsp_target) && $stable(mpu_rsp_target))
        else $error("state moved while clock enable low");

    // Main scenarios
    c_mpu_sdram: cover property (ce && mpu_req_valid ##1 mpu_rsp_target == TGT_SDRAM);
    c_l3_coherent: cover property (ce && l3_req_valid ##1 l3_rsp_coherent);
    c_l3_error: cover property (ce && l3_req_valid ##1 l3_rsp_err);
    c_boot_onchip: cover property (ce && mpu_req_valid && cfg.boot_onchip
                                   && (mpu_req_addr < KB64));

endmodule

// ===== include/sam_pkg.sv
// Constants, target codes and helpers shared by the address router
package sam_pkg;

    // Region bases and spans
    localparam logic [31:0] PERIPH_BASE = 32'hFC00_0000;
    localparam logic [31:0] FABRIC_BASE = 32'hC000_0000;
    localparam logic [31:0] COH_BASE    = 32'h8000_0000;
    localparam logic [31:0] MB_SIZE     = 32'h0010_0000;
    localparam logic [31:0] SPAN_2MB    = 32'h0020_0000;
    localparam logic [31:0] SPAN_48MB   = 32'h0300_0000;
    localparam logic [31:0] KB256       = 32'h0004_0000;
    localparam logic [31:0] KB128       = 32'h0002_0000;
    localparam logic [31:0] KB64        = 32'h0001_0000;
    localparam logic [31:0] KB16        = 32'h0000_4000;
    localparam logic [31:0] KB8         = 32'h0000_2000;
    localparam logic [31:0] KB4         = 32'h0000_1000;

    // Peripheral slave bases
    localparam logic [31:0] TRACE_BASE  = 32'hFC00_0000;
    localparam logic [31:0] DEBUG_BASE  = 32'hFF00_0000;
    localparam logic [31:0] LW_BASE     = 32'hFF20_0000;
    localparam logic [31:0] GV_LW_BASE  = 32'hFF40_0000;
    localparam logic [31:0] GV_S2F_BASE = 32'hFF50_0000;
    localparam logic [31:0] GV_F2S_BASE = 32'hFF60_0000;
    localparam logic [31:0] EMAC_A_BASE = 32'hFF70_0000;
    localparam logic [31:0] EMAC_B_BASE = 32'hFF70_2000;
    localparam logic [31:0] NAND_BASE   = 32'hFF90_0000;
    localparam logic [31:0] QFLASH_BASE = 32'hFFA0_0000;
    localparam logic [31:0] USB_A_BASE  = 32'hFFB0_0000;
    localparam logic [31:0] USB_B_BASE  = 32'hFFB4_0000;
    localparam logic [31:0] SDRREG_BASE = 32'hFFC2_0000;
    localparam logic [31:0] CLK_BASE    = 32'hFFD0_4000;
    localparam logic [31:0] SYS_BASE    = 32'hFFD0_8000;
    localparam logic [31:0] ROM_BASE    = 32'hFFFD_0000;
    localparam logic [31:0] SNOOP_BASE  = 32'hFFFE_C000;
    localparam logic [31:0] L2REG_BASE  = 32'hFFFE_F000;
    localparam logic [31:0] RAM_BASE    = 32'hFFFF_0000;

    // Groups of ordinary 4 KB peripheral-bus slots
    localparam int SLOT_GROUPS = 7;
    localparam logic [31:0] SLOT_BASE [SLOT_GROUPS] = '{32'hFF70_4000, 32'hFF80_0000,
        32'hFFB8_0000, 32'hFFC0_0000, 32'hFFD0_0000, 32'hFFE0_0000, 32'hFFF0_0000};
    localparam logic [31:0] SLOT_SIZE [SLOT_GROUPS] = '{32'h0000_7000, MB_SIZE,
        32'h0001_1000, 32'h0000_A000, 32'h0000_6000, KB16, 32'h0000_3000};

    // Register map and field layout
    localparam int          REG_AW         = 8;
    localparam logic [7:0]  REG_CTRL       = 8'h00;
    localparam logic [7:0]  REG_FILT_START = 8'h04;
    localparam logic [7:0]  REG_FILT_END   = 8'h08;
    localparam logic [7:0]  REG_COH_PAGE   = 8'h0C;
    localparam logic [7:0]  REG_STATUS     = 8'h10;
    localparam int          CTRL_BOOT_BIT  = 0;
    localparam int          CTRL_LOW_BIT   = 1;
    localparam int          FILT_LSB       = 20;
    localparam int          FILT_W         = 12;
    localparam logic [11:0] FILT_START_RST = 12'h001;
    localparam logic [11:0] FILT_END_RST   = 12'hC00;
    localparam int          COH_OFS_W      = 30;
    localparam logic [1:0]  COH_PAGE_RST   = 2'h0;
    localparam int          TGT_W          = 5;
    localparam int          STAT_MPU_LSB   = 0;
    localparam int          STAT_L3_LSB    = 8;
    localparam int          STAT_ERR_LSB   = 16;
    localparam int          ERR_W          = 16;

    // Slave selected by a decode
    typedef enum logic [4:0] {
        TGT_NONE = 5'h00, TGT_SDRAM = 5'h01, TGT_BOOT_ROM = 5'h02, TGT_ONCHIP_RAM = 5'h03,
        TGT_FABRIC = 5'h04, TGT_LIGHT_FABRIC = 5'h05, TGT_TRACE = 5'h06, TGT_DEBUG = 5'h07,
        TGT_LIGHT_VIEW = 5'h08, TGT_S2F_VIEW = 5'h09, TGT_F2S_VIEW = 5'h0A,
        TGT_EMAC_A = 5'h0B, TGT_EMAC_B = 5'h0C, TGT_USB_A = 5'h0D, TGT_USB_B = 5'h0E,
        TGT_SDRAM_REGS = 5'h0F, TGT_NAND_DATA = 5'h10, TGT_QFLASH_DATA = 5'h11,
        TGT_CLOCK_MGR = 5'h12, TGT_SYSTEM_MGR = 5'h13, TGT_SNOOP_CTRL = 5'h14,
        TGT_L2_CACHE_REGS = 5'h15, TGT_COHERENT = 5'h16, TGT_SLOT = 5'h17
    } sam_tgt_e;

    // True when a lies inside [base, base+size)
    function automatic logic hit(input logic [31:0] a, input logic [31:0] base,
                                 input logic [31:0] size);
        return (a >= base) && ((a - base) < size);
    endfunction

endpackage

// ===== include/sam_cfg_if.sv
// Configuration and status carried between register file and router core
`timescale 1ns/1ps
interface sam_cfg_if;
    import sam_pkg::*;
    logic              boot_onchip;
    logic              low_onchip;
    logic [FILT_W-1:0] filt_start;
    logic [FILT_W-1:0] filt_end;
    logic [1:0]        coh_page;
    sam_tgt_e          mpu_last;
    sam_tgt_e          l3_last;
    logic [ERR_W-1:0]  err_count;
    modport regs (output boot_onchip, low_onchip, filt_start, filt_end, coh_page,
                  input mpu_last, l3_last, err_count);
    modport core (input boot_onchip, low_onchip, filt_start, filt_end, coh_page,
                  output mpu_last, l3_last, err_count);
endinterface

// ===== hdl/sam_periph_dec.sv
// Peripheral region slave decoder
`timescale 1ns/1ps
module sam_periph_dec
    import sam_pkg::*;
(
    input  wire logic [31:0] addr,
    input  wire logic        l3_view,
    output sam_tgt_e         tgt
);

    // Later matches override; ordinary slots first
    always_comb
    begin
        tgt = TGT_NONE;
        // RULE_14 slot groups
        for (int i = 0; i < SLOT_GROUPS; i++)
            if (hit(addr, SLOT_BASE[i], SLOT_SIZE[i])) tgt = TGT_SLOT;
        // RULE_12 trace debug
        if (hit(addr, TRACE_BASE, SPAN_48MB))  tgt = TGT_TRACE;
        if (hit(addr, DEBUG_BASE, SPAN_2MB))   tgt = TGT_DEBUG;
        // RULE_03 light fabric
        if (hit(addr, LW_BASE, SPAN_2MB))      tgt = TGT_LIGHT_FABRIC;
        // RULE_13 bridge views
        if (hit(addr, GV_LW_BASE, MB_SIZE))    tgt = TGT_LIGHT_VIEW;
        if (hit(addr, GV_S2F_BASE, MB_SIZE))   tgt = TGT_S2F_VIEW;
        if (hit(addr, GV_F2S_BASE, MB_SIZE))   tgt = TGT_F2S_VIEW;
        // RULE_14 mac and clock
        if (hit(addr, EMAC_A_BASE, KB8))       tgt = TGT_EMAC_A;
        if (hit(addr, EMAC_B_BASE, KB8))       tgt = TGT_EMAC_B;
        if (hit(addr, CLK_BASE, KB4))          tgt = TGT_CLOCK_MGR;
        // RULE_20 flash windows
        if (hit(addr, NAND_BASE, MB_SIZE))     tgt = TGT_NAND_DATA;
        if (hit(addr, QFLASH_BASE, MB_SIZE))   tgt = TGT_QFLASH_DATA;
        // RULE_15 usb spans
        if (hit(addr, USB_A_BASE, KB256))      tgt = TGT_USB_A;
        if (hit(addr, USB_B_BASE, KB256))      tgt = TGT_USB_B;
        // RULE_16 sdram regs
        if (hit(addr, SDRREG_BASE, KB128))     tgt = TGT_SDRAM_REGS;
        // RULE_19 system manager
        if (hit(addr, SYS_BASE, KB16))         tgt = TGT_SYSTEM_MGR;
        // RULE_18 on-chip ram; boot rom decoded below, processor view only
        if (hit(addr, RAM_BASE, KB64))         tgt = TGT_ONCHIP_RAM;
        // RULE_06 hidden from interconnect
        if (!l3_view)
        begin
            // RULE_17 processor slaves
            if (hit(addr, SNOOP_BASE, KB8))    tgt = TGT_SNOOP_CTRL;
            if (hit(addr, L2REG_BASE, KB4))    tgt = TGT_L2_CACHE_REGS;
            if (hit(addr, ROM_BASE, KB64))     tgt = TGT_BOOT_ROM;
        end
    end

endmodule

// ===== hdl/sam_apb_regs.sv
// APB register file for remap, filter window and coherent page
`timescale 1ns/1ps
module sam_apb_regs
    import sam_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              ce,
    input  wire logic [REG_AW-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    sam_cfg_if.regs                cfg
);

    logic        setup;
    logic        mapped;
    logic [31:0] rd;

    assign setup  = psel && !penable;
    assign mapped = (paddr == REG_CTRL) || (paddr == REG_FILT_START) ||
                    (paddr == REG_FILT_END) || (paddr == REG_COH_PAGE) ||
                    (paddr == REG_STATUS);

    // Read mux; unused bits read zero
    always_comb
    begin
        rd = '0;
        case (paddr)
            REG_CTRL:
            begin
                rd[CTRL_BOOT_BIT] = cfg.boot_onchip;
                rd[CTRL_LOW_BIT]  = cfg.low_onchip;
            end
            REG_FILT_START: rd[FILT_LSB +: FILT_W] = cfg.filt_start;
            REG_FILT_END:   rd[FILT_LSB +: FILT_W] = cfg.filt_end;
            REG_COH_PAGE:   rd[1:0] = cfg.coh_page;
            REG_STATUS:
            begin
                rd[STAT_MPU_LSB +: TGT_W] = cfg.mpu_last;
                rd[STAT_L3_LSB +: TGT_W]  = cfg.l3_last;
                rd[STAT_ERR_LSB +: ERR_W] = cfg.err_count;
            end
            default: rd = '0;
        endcase
    end

    // Answer prepared in setup, so access ends after one cycle
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end
        else if (ce)
        begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            if (setup) prdata <= pwrite ? '0 : rd;
        end
    end

    // RULE_25 write at access
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            cfg.boot_onchip <= 1'b0;
            cfg.low_onchip  <= 1'b0;
            cfg.filt_start  <= FILT_START_RST;
            cfg.filt_end    <= FILT_END_RST;
            cfg.coh_page    <= COH_PAGE_RST;
        end
        else if (ce && psel && penable && pready && pwrite)
        begin
            case (paddr)
                REG_CTRL:
                begin
                    cfg.boot_onchip <= pwdata[CTRL_BOOT_BIT];
                    cfg.low_onchip  <= pwdata[CTRL_LOW_BIT];
                end
                REG_FILT_START: cfg.filt_start <= pwdata[FILT_LSB +: FILT_W];
                REG_FILT_END:   cfg.filt_end   <= pwdata[FILT_LSB +: FILT_W];
                REG_COH_PAGE:   cfg.coh_page   <= pwdata[1:0];
                default: ;
            endcase
        end
    end

endmodule

// ===== testbench/sam_mst_model.sv
// Bus master model issuing single-cycle address requests
`timescale 1ns/1ps
module sam_mst_model
(
    input  wire logic   clk_sys,
    output logic        req_valid,
    output logic [31:0] req_addr
);
    // Quiet at time zero
    initial
    begin
        req_valid = 1'b0;
        req_addr  = 32'h0;
    end
    // Released address is inverted so a stale value never matches
    task automatic send(input logic [31:0] a);
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_addr  <= a;
        @(posedge clk_sys);
        req_valid <= 1'b0;
        req_addr  <= ~a;
    endtask
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench for the address router
`timescale 1ns/1ps
module tb_top
    import sam_pkg::*;
;
    logic        clk_sys = 1'b0, rst_n = 1'b0, ce = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, ma, la, mpu_rsp_addr, l3_rsp_addr;
    logic        pready, pslverr, er, mv, lv, mpu_rsp_valid, mpu_rsp_err;
    logic        l3_rsp_valid, l3_rsp_err, l3_rsp_coherent;
    sam_tgt_e    mpu_rsp_target, l3_rsp_target;
    int          num_errors = 0, checks_done = 0;

    // Clock at 10 MHz
    always #50 clk_sys = ~clk_sys;

    sam_mst_model u_mpu (.clk_sys(clk_sys), .req_valid(mv), .req_addr(ma));
    sam_mst_model u_l3 (.clk_sys(clk_sys), .req_valid(lv), .req_addr(la));
    sam_addr_router u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mpu_req_valid(mv), .mpu_req_addr(ma),
        .mpu_rsp_valid(mpu_rsp_valid), .mpu_rsp_target(mpu_rsp_target),
        .mpu_rsp_addr(mpu_rsp_addr), .mpu_rsp_err(mpu_rsp_err), .l3_req_valid(lv),
        .l3_req_addr(la), .l3_rsp_valid(l3_rsp_valid), .l3_rsp_target(l3_rsp_target),
        .l3_rsp_addr(l3_rsp_addr), .l3_rsp_err(l3_rsp_err),
        .l3_rsp_coherent(l3_rsp_coherent));

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Reads right after the edge see pre-edge register values
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Wait for pready; only the watchdog ends a hang here
        do
        begin
            @(posedge clk_sys);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rt(input bit l3, input logic [31:0] a, input sam_tgt_e t);
        if (l3)
            u_l3.send(a);
        else
            u_mpu.send(a);
        #1;
        chk(l3 ? l3_rsp_valid : mpu_rsp_valid, 1'b1);
        chk(l3 ? l3_rsp_target : mpu_rsp_target, t);
        chk(l3 ? l3_rsp_err : mpu_rsp_err, t == TGT_NONE);
        if (l3) chk(l3_rsp_coherent, t == TGT_COHERENT); // flag only in window
    endtask

    task automatic report_and_stop;
        if (num_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Whole run is about a hundred cycles
    initial
    begin
        #1000000;
        num_errors++;
        report_and_stop;
    end

    initial
    begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        apb(0, REG_FILT_START, 0); chk(rd, 32'h00100000); // filter start
        apb(0, REG_FILT_END, 0); chk(rd, 32'hC0000000); // filter end
        apb(0, 8'h40, 0); chk(er, 1'b1); // unmapped offset
        rt(0, 32'h0, TGT_BOOT_ROM); // boot to rom
        rt(0, 32'h00010000, TGT_NONE); // boot hole
        rt(0, 32'h00100000, TGT_SDRAM); // sdram window
        rt(0, 32'hBFFFFFFC, TGT_SDRAM); // window top
        rt(0, 32'hC0000000, TGT_FABRIC); // fabric base
        rt(0, 32'hFC000000, TGT_TRACE); // trace
        rt(0, 32'hFF1FFFFC, TGT_DEBUG); // debug
        rt(0, 32'hFF200000, TGT_LIGHT_FABRIC); // light window
        chk(mpu_rsp_addr, 32'hFF200000); // address kept
        rt(0, 32'hFF500000, TGT_S2F_VIEW); // bridge view
        rt(0, 32'hFF6FFFFC, TGT_F2S_VIEW); // view top
        rt(0, 32'hFF702000, TGT_EMAC_B); // second mac
        rt(0, 32'hFFD04000, TGT_CLOCK_MGR); // clock slot
        rt(0, 32'hFFB40000, TGT_USB_B); // usb
        rt(0, 32'hFFC3FFFC, TGT_SDRAM_REGS); // sdram regs
        rt(0, 32'hFFC40000, TGT_NONE); // unclaimed
        rt(0, 32'hFFD0BFFC, TGT_SYSTEM_MGR); // system manager
        rt(0, 32'hFF900000, TGT_NAND_DATA); // nand
        rt(0, 32'hFFA00000, TGT_QFLASH_DATA); // flash
        rt(0, 32'hFFFEDFFC, TGT_SNOOP_CTRL); // snoop
        rt(0, 32'hFFFEF000, TGT_L2_CACHE_REGS); // cache regs
        rt(0, 32'hFFFD0000, TGT_BOOT_ROM); // rom
        rt(0, 32'hFFFFFFFC, TGT_ONCHIP_RAM); // ram
        rt(1, 32'h0, TGT_SDRAM); // low to sdram
        rt(1, 32'h7FFFFFFC, TGT_SDRAM); // sdram top
        rt(1, 32'h80000010, TGT_COHERENT); // coherent
        chk(l3_rsp_coherent, 1'b1); // coherent flag
        chk(l3_rsp_addr, 32'h00000010); // page zero
        rt(1, 32'hC0000000, TGT_FABRIC); // fabric
        rt(1, 32'hFFFD0000, TGT_NONE); // rom hidden
        rt(1, 32'hFFFEC000, TGT_NONE); // snoop hidden
        rt(1, 32'hFFFF0000, TGT_ONCHIP_RAM); // ram seen
        // Request offered while frozen is not taken
        @(posedge clk_sys) ce <= 1'b0;
        u_mpu.send(32'hFFFD0000);
        #1 ce <= 1'b1;
        chk(mpu_rsp_valid, 1'b0); // frozen while ce low
        chk(mpu_rsp_target, TGT_ONCHIP_RAM); // target held
        apb(1, REG_CTRL, 32'h3); chk(er, 1'b0); // remap write
        rt(1, 32'h0, TGT_ONCHIP_RAM); // low to ram
        rt(0, 32'h0, TGT_ONCHIP_RAM); // boot remapped
        apb(0, REG_STATUS, 0); chk(rd, 32'h00040303); // error count
        apb(1, REG_FILT_START, 32'h0);
        rt(0, 32'h0, TGT_SDRAM); // filter hides boot
        apb(1, REG_FILT_END, 32'hC0100000);
        rt(0, 32'hC0000000, TGT_SDRAM); // filter over fabric
        apb(1, REG_COH_PAGE, 32'h3);
        rt(1, 32'h80000010, TGT_COHERENT); // top page
        chk(l3_rsp_addr, 32'hC0000010); // translated
        report_and_stop;
    end
endmodule
